// [lpd_device.sv]
// Memory-device end: command decode, bank state, power states, masked data path.
// Assumes the controller drives the pins on the same clock and keeps its own bus turns.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module lpd_device (
	// Clock and reset
	input  wire logic                         i_clock,
	input  wire logic                         i_rst_n,
	// Junction sensor, level, high above the threshold
	input  wire logic                         i_temp_hot,
	// Pins
	lpd_bus_if.dev                            bus,
	// Device state seen by the user side
	output logic     [1:0]                    o_power_state,
	output logic     [lpd_pkg::BANKS-1:0]     o_banks_open,
	output logic     [lpd_pkg::ADDR_W-1:0]    o_mode_reg,
	output logic     [lpd_pkg::ADDR_W-1:0]    o_ext_mode_reg
);
	import lpd_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		lpd_pwr_e                    pwr;
		logic                        cke_q;
		logic [BANKS-1:0]            open;
		logic [BANKS-1:0][ADDR_W-1:0] row;
		logic [ADDR_W-1:0]           mode;
		logic [ADDR_W-1:0]           emode;
		logic [3:0]                  rd_left;
		logic [MEM_IDX_W-1:0]        rd_idx;
		logic                        rd_act;
		logic [DQ_W-1:0]             rd_rise;
		logic [DQ_W-1:0]             rd_fall;
		logic [3:0]                  wr_left;
		logic [MEM_IDX_W-1:0]        wr_idx;
		logic                        ap_pend;
		logic [BA_W-1:0]             ap_bank;
		logic [1:0]                  hot_sync;
		logic                        hot;
	} lpd_dev_s;

	lpd_dev_s              s_r;
	lpd_dev_s              s_nxt;
	logic [2:0]            cmd;
	logic                  cke;
	logic                  live;
	logic                  take;
	logic [MEM_IDX_W-1:0]  cmd_idx;
	logic [3:0]            bl_cycles;
	logic [DQ_W-1:0]       mem_rise;
	logic [DQ_W-1:0]       mem_fall;
	logic                  wr_live;

	// Second die pins are never looked at here
	assign cke  = bus.die0_clock_enable;
	assign cmd  = {bus.ras_n, bus.cas_n, bus.we_n};
	// Inputs are dead outside the active state
	assign live = (s_r.pwr == PWR_ACTIVE) && cke;
	assign take = live && s_r.cke_q && !bus.die0_chip_select_n;
	assign cmd_idx = {bus.ba, s_r.row[bus.ba][ROW_IDX_W-1:0],
		bus.addr[COL_LSB +: COL_W], 1'b0};
	assign wr_live = (s_r.pwr == PWR_ACTIVE) && cke && (s_r.wr_left != 4'h0);

	// Burst length in clock cycles; two beats per cycle
	always_comb begin
		case (s_r.mode[BL_LSB +: BL_W])
			3'h2:    bl_cycles = 4'h2;
			3'h3:    bl_cycles = 4'h4;
			3'h4:    bl_cycles = 4'h8;
			default: bl_cycles = 4'h1;
		endcase
	end

	// ****************************************
	// Storage, one array per byte lane
	// ****************************************
	// Small window of the array: two row bits and three column bits per bank
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [7:0] mem [0:(1 << MEM_IDX_W)-1];

			assign mem_rise[8*g +: 8] = mem[s_r.rd_idx];
			assign mem_fall[8*g +: 8] = mem[{s_r.rd_idx[MEM_IDX_W-1:1], 1'b1}];

			// Data only counts when the controller strobe marks the lane
			always_ff @(posedge i_clock) begin
				if (wr_live && bus.dqs[g]) begin
					if (!bus.dm_rise[g]) begin
						mem[s_r.wr_idx] <= bus.dq_rise[8*g +: 8];
					end
					if (!bus.dm_fall[g]) begin
						mem[{s_r.wr_idx[MEM_IDX_W-1:1], 1'b1}] <= bus.dq_fall[8*g +: 8];
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_nxt          = s_r;
		s_nxt.cke_q    = cke;
		s_nxt.hot_sync = {s_r.hot_sync[0], i_temp_hot};
		s_nxt.hot      = s_r.hot_sync[1];
		s_nxt.rd_act   = 1'b0;

		// Read burst, one beat pair per cycle, column wraps inside its three-bit column field whatever the burst length
		if (s_r.rd_left != 4'h0) begin
			s_nxt.rd_act  = 1'b1;
			s_nxt.rd_rise = mem_rise;
			s_nxt.rd_fall = mem_fall;
			s_nxt.rd_left = s_r.rd_left - 4'h1;
			s_nxt.rd_idx[COL_LSB +: COL_W] = s_r.rd_idx[COL_LSB +: COL_W] + 3'h1;
		end
		if (s_r.wr_left != 4'h0) begin
			s_nxt.wr_left = s_r.wr_left - 4'h1;
			s_nxt.wr_idx[COL_LSB +: COL_W] = s_r.wr_idx[COL_LSB +: COL_W] + 3'h1;
		end
		// Auto precharge closes the bank once the burst has drained
		if (s_r.ap_pend && s_r.rd_left == 4'h0 && s_r.wr_left == 4'h0) begin
			s_nxt.open[s_r.ap_bank] = 1'b0;
			s_nxt.ap_pend           = 1'b0;
		end

		case (s_r.pwr)
			PWR_ACTIVE: begin
				if (!cke) begin
					if (!bus.die0_chip_select_n && cmd == CMD_REF && s_r.open == '0) begin
						s_nxt.pwr = PWR_SELF_REF;
					end else if (s_r.open == '0) begin
						s_nxt.pwr = PWR_PD_PRE;
					end else begin
						s_nxt.pwr = PWR_PD_ACT;
					end
					s_nxt.rd_left = 4'h0;
					s_nxt.wr_left = 4'h0;
				end else if (take) begin
					case (cmd)
						CMD_LMR: begin
							if (bus.ba == MR_SEL_BASE) begin
								s_nxt.mode = bus.addr;
							end else if (bus.ba == MR_SEL_EXT) begin
								s_nxt.emode = bus.addr;
							end
						end
						CMD_ACT: begin
							s_nxt.open[bus.ba] = 1'b1;
							s_nxt.row[bus.ba]  = bus.addr;
						end
						CMD_RD: begin
							if (s_r.open[bus.ba] && s_r.wr_left == 4'h0) begin
								s_nxt.rd_left = bl_cycles;
								s_nxt.rd_idx  = cmd_idx;
								s_nxt.ap_pend = bus.addr[AP_BIT];
								s_nxt.ap_bank = bus.ba;
							end
						end
						CMD_WR: begin
							// Refused while a read still owns the data lines
							if (s_r.open[bus.ba] && s_r.rd_left == 4'h0 && !s_r.rd_act) begin
								s_nxt.wr_left = bl_cycles;
								s_nxt.wr_idx  = cmd_idx;
								s_nxt.ap_pend = bus.addr[AP_BIT];
								s_nxt.ap_bank = bus.ba;
							end
						end
						CMD_PRE: begin
							if (bus.addr[AP_BIT]) begin
								s_nxt.open = '0;
							end else begin
								s_nxt.open[bus.ba] = 1'b0;
							end
						end
						default: begin
						end
					endcase
				end
			end
			PWR_PD_PRE, PWR_PD_ACT: begin
				// Synchronous exit: enable must be seen high on two edges
				if (cke && s_r.cke_q) begin
					s_nxt.pwr = PWR_ACTIVE;
				end
			end
			PWR_SELF_REF: begin
				// Exit on the first edge the level is high, no prior sample needed
				if (cke) begin
					s_nxt.pwr = PWR_ACTIVE;
				end
			end
			default: begin
				s_nxt.pwr = PWR_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Drivers follow the enable pin at once so a falling enable frees the bus
	assign bus.dev_dq_rise_o      = s_r.rd_rise;
	assign bus.dev_dq_fall_o      = s_r.rd_fall;
	assign bus.dev_dq_oe_n        = !(s_r.rd_act && cke);
	assign bus.dev_dqs_o          = {LANES{s_r.rd_act}};
	assign bus.over_temp_flag_out = s_r.hot;
	assign o_power_state          = s_r.pwr;
	assign o_banks_open           = s_r.open;
	assign o_mode_reg             = s_r.mode;
	assign o_ext_mode_reg         = s_r.emode;

endmodule // lpd_device

`default_nettype wire

// [lpd_pkg.sv]
// Constants, types and layouts shared by the memory-device end and the controller end.
// Assumes one clock for both ends; each clock cycle carries a rise beat and a fall beat.
`default_nettype none

package lpd_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int DQ_W      = 16;
	localparam int LANES     = 2;
	localparam int ADDR_W    = 14;
	localparam int BA_W      = 2;
	localparam int BANKS     = 4;
	localparam int MEM_IDX_W = 8;
	localparam int REG_A_W   = 3;
	localparam int IRQ_W     = 3;

	// ****************************************
	// Address field positions
	// ****************************************
	localparam int AP_BIT    = 10;
	localparam int COL_LSB   = 1;
	localparam int COL_W     = 3;
	localparam int ROW_IDX_W = 2;
	localparam int BL_LSB    = 0;
	localparam int BL_W      = 3;

	// Command code as {ras_n, cas_n, we_n}, taken with chip select low
	localparam logic [2:0] CMD_LMR = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_WR  = 3'h4;
	localparam logic [2:0] CMD_RD  = 3'h5;
	localparam logic [2:0] CMD_NOP = 3'h7;

	// Mode register select on the bank address
	localparam logic [BA_W-1:0] MR_SEL_BASE = 2'h0;
	localparam logic [BA_W-1:0] MR_SEL_EXT  = 2'h2;

	// ****************************************
	// Controller register map (word index)
	// ****************************************
	localparam logic [REG_A_W-1:0] REG_CTRL   = 3'h0;
	localparam logic [REG_A_W-1:0] REG_CMD    = 3'h1;
	localparam logic [REG_A_W-1:0] REG_WDATA  = 3'h2;
	localparam logic [REG_A_W-1:0] REG_WMASK  = 3'h3;
	localparam logic [REG_A_W-1:0] REG_RDATA  = 3'h4;
	localparam logic [REG_A_W-1:0] REG_STATUS = 3'h5;
	localparam logic [REG_A_W-1:0] REG_MASK   = 3'h6;
	localparam logic [REG_A_W-1:0] REG_PINS   = 3'h7;

	localparam int CTRL_CKE_BIT = 0;
	localparam int CTRL_WB_LSB  = 4;
	localparam int CTRL_WB_W    = 4;
	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_BA_LSB   = 4;
	localparam int CMD_ADDR_LSB = 8;

	localparam int ST_RD_DONE  = 0;
	localparam int ST_CMD_SENT = 1;
	localparam int ST_TEMP_HOT = 2;

	localparam logic [31:0]      CTRL_RST = 32'h00000011;
	localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

	// ****************************************
	// Device power states
	// ****************************************
	typedef enum logic [1:0] {
		PWR_ACTIVE   = 2'b00,
		PWR_PD_PRE   = 2'b01,
		PWR_PD_ACT   = 2'b10,
		PWR_SELF_REF = 2'b11
	} lpd_pwr_e;

endpackage

`default_nettype wire

// [lpd_bus_if.sv]
// Pin bundle between the memory device and its controller.
// Assumes both ends run on one clock; shared data and strobe lines are resolved here.
`timescale 1ns/10ps
`default_nettype none

interface lpd_bus_if;
	import lpd_pkg::*;

	logic                   die0_clock_enable;
	logic                   die1_clock_enable;
	logic                   die0_chip_select_n;
	logic                   die1_chip_select_n;
	logic                   ras_n;
	logic                   cas_n;
	logic                   we_n;
	logic [BA_W-1:0]        ba;
	logic [ADDR_W-1:0]      addr;
	logic [LANES-1:0]       dm_rise;
	logic [LANES-1:0]       dm_fall;
	logic [DQ_W-1:0]        host_dq_rise_o;
	logic [DQ_W-1:0]        host_dq_fall_o;
	logic                   host_dq_oe_n;
	logic [LANES-1:0]       host_dqs_o;
	logic [DQ_W-1:0]        dev_dq_rise_o;
	logic [DQ_W-1:0]        dev_dq_fall_o;
	logic                   dev_dq_oe_n;
	logic [LANES-1:0]       dev_dqs_o;
	logic                   over_temp_flag_out;
	logic [DQ_W-1:0]        dq_rise;
	logic [DQ_W-1:0]        dq_fall;
	logic [LANES-1:0]       dqs;

	// Undriven lines read as zero rather than floating
	assign dq_rise = !dev_dq_oe_n ? dev_dq_rise_o : (!host_dq_oe_n ? host_dq_rise_o : '0);
	assign dq_fall = !dev_dq_oe_n ? dev_dq_fall_o : (!host_dq_oe_n ? host_dq_fall_o : '0);
	assign dqs     = !dev_dq_oe_n ? dev_dqs_o : (!host_dq_oe_n ? host_dqs_o : '0);

	modport dev (
		input  die0_clock_enable, die1_clock_enable, die0_chip_select_n, die1_chip_select_n,
		input  ras_n, cas_n, we_n, ba, addr, dm_rise, dm_fall, dq_rise, dq_fall, dqs,
		output dev_dq_rise_o, dev_dq_fall_o, dev_dq_oe_n, dev_dqs_o, over_temp_flag_out
	);

	modport host (
		output die0_clock_enable, die1_clock_enable, die0_chip_select_n, die1_chip_select_n,
		output ras_n, cas_n, we_n, ba, addr, dm_rise, dm_fall,
		output host_dq_rise_o, host_dq_fall_o, host_dq_oe_n, host_dqs_o,
		input  dq_rise, dq_fall, dqs, over_temp_flag_out
	);

endinterface

`default_nettype wire

// [lpd_host.sv]
// Controller end: software registers in, device pins out, read capture and interrupt.
// Assumes a plain register port with read data one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none

module lpd_host (
	// Clock and reset
	input  wire logic                         i_clock,
	input  wire logic                         i_rst_n,
	// Register port
	input  wire logic [lpd_pkg::REG_A_W-1:0]  i_reg_addr,
	input  wire logic [31:0]                  i_reg_wdata,
	input  wire logic                         i_reg_wr,
	input  wire logic                         i_reg_rd,
	output logic      [31:0]                  o_reg_rdata,
	output logic                              o_irq,
	// Pins
	lpd_bus_if.host                           bus
);
	import lpd_pkg::*;

	typedef struct packed {
		logic [31:0]       ctrl;
		logic [31:0]       wdata;
		logic [3:0]        wmask;
		logic [31:0]       rdata;
		logic [IRQ_W-1:0]  status;
		logic [IRQ_W-1:0]  mask;
		logic              cs_n;
		logic [2:0]        code;
		logic [BA_W-1:0]   ba;
		logic [ADDR_W-1:0] addr;
		logic              wr_arm;
		logic [3:0]        wr_left;
		logic [31:0]       reg_rdata;
		logic [1:0]        hot_sync;
		logic              hot_q;
		logic              cke;
	} lpd_host_s;

	lpd_host_s         s_r;
	lpd_host_s         s_nxt;
	logic [IRQ_W-1:0]  ev;
	logic [3:0]        wb;

	assign wb = (s_r.ctrl[CTRL_WB_LSB +: CTRL_WB_W] == 4'h0) ? 4'h1
		: s_r.ctrl[CTRL_WB_LSB +: CTRL_WB_W];

	always_comb begin
		s_nxt          = s_r;
		ev             = '0;
		s_nxt.cs_n     = 1'b1;
		s_nxt.code     = CMD_NOP;
		s_nxt.wr_arm   = 1'b0;
		s_nxt.hot_sync = {s_r.hot_sync[0], bus.over_temp_flag_out};
		s_nxt.hot_q    = s_r.hot_sync[1];
		s_nxt.cke      = s_r.ctrl[CTRL_CKE_BIT];
		ev[ST_TEMP_HOT] = s_r.hot_sync[1] && !s_r.hot_q;

		// Write data phase follows the command by one cycle
		if (s_r.wr_arm) begin
			s_nxt.wr_left = wb;
		end else if (s_r.wr_left != 4'h0) begin
			s_nxt.wr_left = s_r.wr_left - 4'h1;
		end

		// Only the device strobe can be high while this end is not driving
		if (bus.dqs[0] && s_r.wr_left == 4'h0) begin
			s_nxt.rdata        = {bus.dq_fall, bus.dq_rise};
			ev[ST_RD_DONE]     = 1'b1;
		end

		if (i_reg_wr) begin
			case (i_reg_addr)
				REG_CTRL:  s_nxt.ctrl  = i_reg_wdata;
				REG_WDATA: s_nxt.wdata = i_reg_wdata;
				REG_WMASK: s_nxt.wmask = i_reg_wdata[3:0];
				REG_MASK:  s_nxt.mask  = i_reg_wdata[IRQ_W-1:0];
				REG_CMD: begin
					s_nxt.cs_n      = 1'b0;
					s_nxt.code      = i_reg_wdata[CMD_CODE_LSB +: 3];
					s_nxt.ba        = i_reg_wdata[CMD_BA_LSB +: BA_W];
					s_nxt.addr      = i_reg_wdata[CMD_ADDR_LSB +: ADDR_W];
					s_nxt.wr_arm    = (i_reg_wdata[CMD_CODE_LSB +: 3] == CMD_WR);
					ev[ST_CMD_SENT] = 1'b1;
				end
				default: begin
				end
			endcase
		end

		s_nxt.reg_rdata = 32'h00000000;
		if (i_reg_rd) begin
			case (i_reg_addr)
				REG_CTRL:   s_nxt.reg_rdata = s_r.ctrl;
				REG_CMD:    s_nxt.reg_rdata = {8'h00, 2'h0, s_r.addr, 2'h0, s_r.ba, 1'b0, s_r.code};
				REG_WDATA:  s_nxt.reg_rdata = s_r.wdata;
				REG_WMASK:  s_nxt.reg_rdata = {28'h0000000, s_r.wmask};
				REG_RDATA:  s_nxt.reg_rdata = s_r.rdata;
				REG_STATUS: begin
					s_nxt.reg_rdata = {29'h00000000, s_r.status};
					s_nxt.status    = '0;
				end
				REG_MASK:   s_nxt.reg_rdata = {29'h00000000, s_r.mask};
				REG_PINS:   s_nxt.reg_rdata = {30'h00000000, s_r.hot_q, s_r.ctrl[CTRL_CKE_BIT]};
				default:    s_nxt.reg_rdata = 32'h00000000;
			endcase
		end
		// New events win over a clearing read in the same cycle
		s_nxt.status = s_nxt.status | ev;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s_r      <= '0;
			s_r.ctrl <= CTRL_RST;
			s_r.mask <= MASK_RST;
			s_r.code <= CMD_NOP;
			s_r.cs_n <= 1'b1;
			s_r.cke  <= CTRL_RST[CTRL_CKE_BIT];
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Pins
	// ****************************************
	// One stage behind CTRL so a CMD write right after it meets the same edge;
	// without that a refresh can never pair with a falling enable
	assign bus.die0_clock_enable  = s_r.cke;
	assign bus.die1_clock_enable  = 1'b0;
	assign bus.die1_chip_select_n = 1'b1;
	assign bus.die0_chip_select_n = s_r.cs_n;
	assign bus.ras_n              = s_r.code[2];
	assign bus.cas_n              = s_r.code[1];
	assign bus.we_n               = s_r.code[0];
	assign bus.ba                 = s_r.ba;
	assign bus.addr               = s_r.addr;
	assign bus.host_dq_rise_o     = s_r.wdata[DQ_W-1:0];
	assign bus.host_dq_fall_o     = s_r.wdata[31:DQ_W];
	assign bus.dm_rise            = s_r.wmask[1:0];
	assign bus.dm_fall            = s_r.wmask[3:2];
	assign bus.host_dq_oe_n       = (s_r.wr_left == 4'h0);
	assign bus.host_dqs_o         = {LANES{s_r.wr_left != 4'h0}};
	assign o_reg_rdata            = s_r.reg_rdata;
	assign o_irq                  = |(s_r.status & s_r.mask);

endmodule // lpd_host

`default_nettype wire

// [lpd_bus_monitor.sv]
// Checker of pin timing between the controller end and the device end.
// Assumes it is instantiated beside the bus interface, on the one shared clock.
`timescale 1ns/10ps
`default_nettype none

module lpd_bus_monitor (
	// Clock and reset
	input wire logic                       i_clock,
	input wire logic                       i_rst_n,
	// Pins
	input wire logic                       die0_clock_enable,
	input wire logic                       die1_clock_enable,
	input wire logic                       die0_chip_select_n,
	input wire logic                       die1_chip_select_n,
	input wire logic                       ras_n,
	input wire logic                       cas_n,
	input wire logic                       we_n,
	input wire logic                       host_dq_oe_n,
	input wire logic [lpd_pkg::LANES-1:0]  host_dqs_o,
	input wire logic                       dev_dq_oe_n,
	input wire logic [lpd_pkg::LANES-1:0]  dev_dqs_o
);
	import lpd_pkg::*;

	logic rd_cmd;
	logic wr_cmd;

	// ****************************************
	// Checks
	// ****************************************
	assign rd_cmd = !die0_chip_select_n && die0_clock_enable && {ras_n, cas_n, we_n} == CMD_RD;
	assign wr_cmd = !die0_chip_select_n && {ras_n, cas_n, we_n} == CMD_WR;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	chk_die1_unused: assert property (!die1_clock_enable && die1_chip_select_n)
		else $error("second die pins in use");
	chk_one_driver: assert property (host_dq_oe_n || dev_dq_oe_n)
		else $error("both ends drive the data lines");
	chk_read_latency: assert property ($fell(dev_dq_oe_n) |-> $past(rd_cmd, 2))
		else $error("read data without a read two cycles before");
	chk_read_strobe: assert property (!dev_dq_oe_n |-> dev_dqs_o == '1)
		else $error("read data without strobe");
	chk_write_strobe: assert property (!host_dq_oe_n |-> host_dqs_o == '1)
		else $error("write data without strobe");
	chk_write_turn: assert property (wr_cmd |=> !host_dq_oe_n)
		else $error("write data late");
	chk_host_burst: assert property ($fell(host_dq_oe_n) |-> $past(wr_cmd))
		else $error("host drives without a write");
	chk_idle_nop: assert property (
		die0_chip_select_n |-> {ras_n, cas_n, we_n} == CMD_NOP)
		else $error("strobes active while deselected");
	// Two low samples so a drive launched just before the drop may finish
	chk_drivers_off: assert property (
		!die0_clock_enable && !$past(die0_clock_enable) |-> dev_dq_oe_n)
		else $error("device drives while clock enable low");

	cov_read: cover property (rd_cmd);
	cov_write: cover property (wr_cmd);
	cov_read_data: cover property ($fell(dev_dq_oe_n));
	cov_power_down: cover property (!die0_clock_enable);
	cov_self_ref: cover property (!die0_clock_enable && !die0_chip_select_n
		&& {ras_n, cas_n, we_n} == CMD_REF);

endmodule // lpd_bus_monitor

`default_nettype wire

// [test_lpddr_sdram_pin_interface.sv]
// Testbench: controller and device joined by the bus, driven through registers.
// Assumes the register map and latencies of the controller end.
`timescale 1ns/10ps
`default_nettype none

module test_lpddr_sdram_pin_interface;
	import lpd_pkg::*;

	logic              clk;
	logic              rst_n;
	logic [REG_A_W-1:0] ra;
	logic [31:0]       wd;
	logic              ws;
	logic              rs;
	logic              hot;
	logic [31:0]       rdata;
	logic              irq;
	logic [1:0]        pwr;
	logic [BANKS-1:0]  bo;
	logic [ADDR_W-1:0] mr;
	logic [ADDR_W-1:0] emr;
	int                fail_count;
	int                checked;
	int                cyc;
	int unsigned       mem[int];

	lpd_bus_if lpd_bus_if_i ();
	lpd_device lpd_device_i (.i_clock(clk), .i_rst_n(rst_n), .i_temp_hot(hot),
		.bus(lpd_bus_if_i), .o_power_state(pwr), .o_banks_open(bo),
		.o_mode_reg(mr), .o_ext_mode_reg(emr));
	lpd_host lpd_host_i (.i_clock(clk), .i_rst_n(rst_n), .i_reg_addr(ra),
		.i_reg_wdata(wd), .i_reg_wr(ws), .i_reg_rd(rs), .o_reg_rdata(rdata),
		.o_irq(irq), .bus(lpd_bus_if_i));
	lpd_bus_monitor lpd_bus_monitor_i (.i_clock(clk), .i_rst_n(rst_n),
		.die0_clock_enable(lpd_bus_if_i.die0_clock_enable),
		.die1_clock_enable(lpd_bus_if_i.die1_clock_enable),
		.die0_chip_select_n(lpd_bus_if_i.die0_chip_select_n),
		.die1_chip_select_n(lpd_bus_if_i.die1_chip_select_n),
		.ras_n(lpd_bus_if_i.ras_n), .cas_n(lpd_bus_if_i.cas_n), .we_n(lpd_bus_if_i.we_n),
		.host_dq_oe_n(lpd_bus_if_i.host_dq_oe_n), .host_dqs_o(lpd_bus_if_i.host_dqs_o),
		.dev_dq_oe_n(lpd_bus_if_i.dev_dq_oe_n), .dev_dqs_o(lpd_bus_if_i.dev_dqs_o));

	// ****************************************
	// Clock, timeout, tasks
	// ****************************************
	always #2 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (fail_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(logic [REG_A_W-1:0] a, logic [31:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		ws <= 1'b1;
		@(posedge clk);
		ws <= 1'b0;
	endtask

	task automatic rd(logic [REG_A_W-1:0] a, output logic [31:0] d);
		@(posedge clk);
		ra <= a;
		rs <= 1'b1;
		@(posedge clk);
		rs <= 1'b0;
		#1 d = rdata;
	endtask

	// Command word: code, bank, address; a few idle cycles let the burst finish
	task automatic cmd(logic [2:0] c, logic [1:0] b, logic [13:0] a);
		wr(REG_CMD, {10'h0, a, 2'h0, b, 1'b0, c});
		repeat (4) @(posedge clk);
	endtask

	task automatic wait_read(output logic [31:0] d);
		logic [31:0] s;
		s = 0;
		for (int i = 0; i < 20 && s[ST_RD_DONE] !== 1'b1; i++) rd(REG_STATUS, s);
		cmp("read done", 1, s[ST_RD_DONE]);
		rd(REG_RDATA, d);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		logic [31:0] d, w, m;
		logic [13:0] op, col[4], row[4];
		int k;
		clk = 0; rst_n = 0; ra = 0; wd = 0; ws = 0; rs = 0; hot = 0;
		fail_count = 0; checked = 0; cyc = 0;
		void'($urandom(32'h1b679023));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(REG_CTRL, d);
		cmp("ctrl reset", CTRL_RST, d);
		rd(REG_MASK, d);
		cmp("mask reset", {29'h0, MASK_RST}, d & 32'h7);
		op = $urandom & 14'h3FF8;
		cmd(CMD_LMR, MR_SEL_BASE, op);
		cmp("mode", op, mr);
		cmd(CMD_LMR, 2'h1, ~op);
		cmp("mode kept", op, mr);
		cmd(CMD_LMR, MR_SEL_EXT, ~op);
		// Concatenation keeps the inversion at 14 bits
		cmp("ext mode", {18'h00000, ~op}, emr);
		for (int b = 0; b < 4; b++) begin
			row[b] = $urandom & 14'h3;
			col[b] = ($urandom & 14'h7) << COL_LSB;
			k = {b[1:0], row[b][1:0], col[b][3:1]};
			cmd(CMD_ACT, b, row[b]);
			cmp("bank open", 1, bo[b]);
			w = $urandom;
			wr(REG_WDATA, w);
			wr(REG_WMASK, 0);
			cmd(CMD_WR, b, col[b]);
			mem[k] = w;
			w = $urandom;
			m = $urandom & 32'hF;
			wr(REG_WDATA, w);
			wr(REG_WMASK, m);
			cmd(CMD_WR, b, col[b]);
			for (int i = 0; i < 4; i++) if (!m[i]) mem[k][8*i+:8] = w[8*i+:8];
			cmd(CMD_RD, b, col[b]);
			wait_read(d);
			cmp("read data", mem[k], d);
		end
		cmp("all open", 4'hF, bo);
		wr(REG_CTRL, 32'h10);
		repeat (4) @(posedge clk);
		cmp("active pd", PWR_PD_ACT, pwr);
		// Power-down needs enable high on two edges: still down one edge short
		wr(REG_CTRL, 32'h11);
		repeat (3) @(posedge clk);
		cmp("pd hold", PWR_PD_ACT, pwr);
		@(posedge clk);
		cmp("pd exit", PWR_ACTIVE, pwr);
		cmd(CMD_PRE, 2'h1, 14'h0);
		cmp("pre one", 4'hD, bo);
		cmd(CMD_RD, 2'h0, col[0] | 14'h400);
		wait_read(d);
		cmp("auto pre data", mem[{2'h0, row[0][1:0], col[0][3:1]}], d);
		cmp("auto pre", 4'hC, bo);
		cmd(CMD_PRE, 2'h3, 14'h400);
		cmp("pre all", 4'h0, bo);
		wr(REG_CTRL, 32'h10);
		repeat (4) @(posedge clk);
		cmp("pre pd", PWR_PD_PRE, pwr);
		cmd(CMD_ACT, 2'h2, 14'h0);
		cmp("pd ignores", 4'h0, bo);
		wr(REG_CTRL, 32'h11);
		repeat (4) @(posedge clk);
		// Enable drop and refresh command back to back meet one edge
		@(posedge clk);
		ra <= REG_CTRL;
		wd <= 32'h00000010;
		ws <= 1'b1;
		@(posedge clk);
		ra <= REG_CMD;
		wd <= {29'h00000000, CMD_REF};
		@(posedge clk);
		ws <= 1'b0;
		repeat (3) @(posedge clk);
		cmp("self refresh", PWR_SELF_REF, pwr);
		// Self refresh leaves on the first high sample, one edge before power-down
		wr(REG_CTRL, 32'h11);
		repeat (3) @(posedge clk);
		cmp("sr exit", PWR_ACTIVE, pwr);
		rd(REG_STATUS, d);
		wr(REG_MASK, 32'h2);
		cmd(CMD_NOP, 2'h0, 14'h0);
		cmp("irq sent", 1, irq);
		rd(REG_STATUS, d);
		cmp("sent", 32'h2, d & 32'h2);
		cmp("irq clear", 0, irq);
		wr(REG_MASK, 32'h4);
		hot <= 1'b1;
		repeat (8) @(posedge clk);
		cmp("flag hot", 1, lpd_bus_if_i.over_temp_flag_out);
		cmp("irq hot", 1, irq);
		rd(REG_PINS, d);
		cmp("pins hot", 32'h00000003, d);
		rd(REG_STATUS, d);
		cmp("hot status", 32'h4, d & 32'h4);
		hot <= 1'b0;
		repeat (8) @(posedge clk);
		cmp("flag cool", 0, lpd_bus_if_i.over_temp_flag_out);
		cmp("irq off", 0, irq);
		finish_test();
	end

endmodule // test_lpddr_sdram_pin_interface

`default_nettype wire
